// file: gated_time_digitizer_bench.sv
// Bench for gtd_digitizer with converter model; inputs change at falling edge.
`default_nettype none
module gated_time_digitizer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, gate_in = 0, test_cmd = 0, readout_en = 0, integ_window, charge_switch;
  logic full_scale_window, counter_clear, readout_oe;
  logic [3:0] readout_sel = 4'h0;
  logic [15:0] time_pulse;
  logic [10:0] readout_data;
  int mismatches, tests_run, cyc, n;
  gtd_digitizer dut (.clk(clk), .rst_n(rst_n), .gate_in(gate_in), .test_cmd(test_cmd), .time_pulse(time_pulse),
    .readout_sel(readout_sel), .readout_en(readout_en), .integ_window(integ_window), .charge_switch(charge_switch),
    .full_scale_window(full_scale_window), .counter_clear(counter_clear), .readout_data(readout_data),
    .readout_oe(readout_oe));
  gtd_qtc_model qtc (.clk(clk), .integ_window(integ_window), .full_scale_window(full_scale_window),
    .time_pulse(time_pulse));
  initial forever #12.5 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic wait_idle();
    for (n = 0; n < 3000 && full_scale_window !== 1'b1; n++) @(negedge clk);
    for (n = 0; n < 3000 && full_scale_window !== 1'b0; n++) @(negedge clk);
  endtask : wait_idle
  // Second command mid-pulse must not stretch or restart it
  task automatic t_test_pulse();
    int w = 0, c = 0, fi = 0, fc = 0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk);
      test_cmd = (k == 0 || k == 10);
      if (integ_window === 1'b1 && w++ == 0) fi = k;
      if (charge_switch === 1'b1 && c++ == 0) fc = k;
    end
    check(w, 22);
    check(c, 20);
    check(fc - fi, 1);
    wait_idle();
  endtask : t_test_pulse
  // Gate conversion, refused readout while busy, then all channels incl. wrap
  task automatic t_convert();
    @(negedge clk) gate_in = 1'b1;
    repeat (10) @(negedge clk);
    gate_in = 1'b0;
    for (n = 0; n < 100 && full_scale_window !== 1'b1; n++) @(negedge clk);
    readout_en = 1'b1;
    repeat (2) @(negedge clk);
    check(readout_oe, 0);
    wait_idle();
    for (int i = 0; i < 16; i++) begin
      readout_sel = 4'(i);
      repeat (2) @(negedge clk);
      check(readout_oe, 1);
      // Pulse stays high i*137+6 full scale cycles after the model and the two sync stages
      check(readout_data, 32'((i * 137 + 6) % 2048));
    end
    readout_en = 1'b0;
  endtask : t_convert
  always @(posedge clk) begin
    if (++cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(negedge clk);
    check(readout_oe, 0);
    rst_n = 1'b1;
    t_test_pulse();
    t_convert();
    complete_run();
  end
endmodule : gated_time_digitizer_bench
bind gtd_digitizer gtd_digitizer_assertions #(.FULL_SCALE_CYC(FULL_SCALE_CYC)) u_chk (.clk(clk), .rst_n(rst_n),
  .readout_en(readout_en), .integ_window(integ_window), .charge_switch(charge_switch),
  .full_scale_window(full_scale_window), .counter_clear(counter_clear), .readout_oe(readout_oe));
`default_nettype wire

// file: gtd_digitizer.sv
// Gated time digitizer: test pulse sequencer, gray phase generator,
// per-channel interpolators and coarse counters, readout bus driver.
// Assumes gate, test command and time pulses arrive asynchronously.
`default_nettype none
// What this block does
// - Crate test command fires one 550 ns test pulse.
// - Test pulse opens window; one cycle (25 ns) later charge switch closes for all channels.
// - Each interpolator has four latches on four phases spaced one 25 ns clock cycle.
// - Phase bits step as a Gray sequence, one bit change per step.
// - Interpolator captures gray state on falling time pulse, then holds.
// - Captured gray bits decode to binary as result low three bits.
// - Coarse counter increments on fourth latch falling edge, the 7 to 0 wrap.
// - Sixteen independent 8-bit coarse counters with hold latch, read through one selected output with an enable.
// - Coarse counters cleared by 400 ns pulse at window end.
// - Hold latches follow counters during full scale window, then freeze.
// - Result is 11 bits: latched coarse high, decoded fine low.
// - Full scale window slightly longer than full-scale digitization time.
// - Phase generator divides the fast clock into four spaced phases.
// - Phase generator halted for 400 ns at window end, runs until full scale ends.
module gtd_digitizer #(
  parameter int unsigned FULL_SCALE_CYC = gtd_pkg::FULL_SCALE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic gate_in,
  input wire logic test_cmd,
  input wire logic [gtd_pkg::NUM_CHANNELS-1:0] time_pulse,
  input wire logic [3:0] readout_sel,
  input wire logic readout_en,
  output logic integ_window,
  output logic charge_switch,
  output logic full_scale_window,
  output logic counter_clear,
  output logic [gtd_pkg::RESULT_BITS-1:0] readout_data,
  output logic readout_oe
);
  localparam int unsigned N = gtd_pkg::NUM_CHANNELS;
  localparam int unsigned CB = gtd_pkg::COARSE_BITS;
  localparam int unsigned PB = gtd_pkg::PHASE_BITS;
  localparam int unsigned WB = gtd_pkg::CNT_BITS;

  // Johnson states are Gray: ones count gives value while filling, mirrored while draining
  function automatic logic [gtd_pkg::FINE_BITS-1:0] gtd_phase_to_bin(input logic [3:0] p);
    logic [3:0] ones;
    ones = {3'h0, p[0]} + {3'h0, p[1]} + {3'h0, p[2]} + {3'h0, p[3]};
    if (p[3] && !p[0]) begin
      gtd_phase_to_bin = 3'(4'h8 - ones);
    end else begin
      gtd_phase_to_bin = ones[2:0];
    end
  endfunction : gtd_phase_to_bin

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic gate_m_q, gate_s_q, test_m_q, test_s_q, test_prev_q;
  logic [N-1:0] time_m_q, time_s_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gate_m_q <= 1'b0;
      gate_s_q <= 1'b0;
      test_m_q <= 1'b0;
      test_s_q <= 1'b0;
      test_prev_q <= 1'b0;
      time_m_q <= '0;
      time_s_q <= '0;
    end else begin
      gate_m_q <= gate_in;
      gate_s_q <= gate_m_q;
      test_m_q <= test_cmd;
      test_s_q <= test_m_q;
      test_prev_q <= test_s_q;
      time_m_q <= time_pulse;
      time_s_q <= time_m_q;
    end
  end

  // ----------------------------------------
  // Test pulse sequencer
  // ----------------------------------------
  logic [WB-1:0] test_cnt_q, test_cnt_d;
  logic test_q, test_d, charge_q, charge_d;
  always_comb begin
    test_d = test_q;
    test_cnt_d = test_cnt_q;
    charge_d = 1'b0;
    if (test_s_q && !test_prev_q && !test_q) begin
      test_d = 1'b1;
      test_cnt_d = '0;
    end else if (test_q) begin
      test_cnt_d = test_cnt_q + 1'b1;
      if (test_cnt_q == WB'(gtd_pkg::TEST_PULSE_CYC - 1)) begin
        test_d = 1'b0;
      end
      // Charge dumps into all channels after the delay, till one cycle before pulse end
      charge_d = (test_cnt_q >= WB'(gtd_pkg::CHARGE_DELAY_CYC)) &&
                 (test_cnt_q != WB'(gtd_pkg::TEST_PULSE_CYC - 1));
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      test_q <= 1'b0;
      test_cnt_q <= '0;
      charge_q <= 1'b0;
    end else begin
      test_q <= test_d;
      test_cnt_q <= test_cnt_d;
      charge_q <= charge_d;
    end
  end

  // ----------------------------------------
  // Conversion sequence and phase generator
  // ----------------------------------------
  gtd_pkg::gtd_state_t state_q, state_d;
  logic [WB-1:0] seq_cnt_q, seq_cnt_d;
  logic [PB-1:0] phase_q, phase_d;
  logic window_d;
  always_comb begin
    window_d = gate_s_q | test_q;
    state_d = state_q;
    seq_cnt_d = seq_cnt_q + 1'b1;
    phase_d = gtd_pkg::PHASE_RESET;
    unique case (state_q)
      gtd_pkg::GTD_IDLE: begin
        if (window_d) begin
          state_d = gtd_pkg::GTD_INTEG;
        end
      end
      gtd_pkg::GTD_INTEG: begin
        seq_cnt_d = '0;
        if (!window_d) begin
          state_d = gtd_pkg::GTD_CLEAR;
        end
      end
      gtd_pkg::GTD_CLEAR: begin
        // Phase held at reset so every conversion starts aligned
        if (seq_cnt_q == WB'(gtd_pkg::CLEAR_CYC - 1)) begin
          state_d = gtd_pkg::GTD_FULLSCALE;
          seq_cnt_d = '0;
        end
      end
      gtd_pkg::GTD_FULLSCALE: begin
        phase_d = {phase_q[PB-2:0], ~phase_q[PB-1]};
        if (seq_cnt_q == WB'(FULL_SCALE_CYC - 1)) begin
          state_d = gtd_pkg::GTD_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= gtd_pkg::GTD_IDLE;
      seq_cnt_q <= '0;
      phase_q <= gtd_pkg::PHASE_RESET;
    end else begin
      state_q <= state_d;
      seq_cnt_q <= seq_cnt_d;
      phase_q <= phase_d;
    end
  end

  // ----------------------------------------
  // Channel interpolators and coarse counters
  // ----------------------------------------
  logic clearing, converting;
  logic [N-1:0][PB-1:0] interp_q, interp_d;
  logic [N-1:0][CB-1:0] coarse_q, coarse_d, hold_q, hold_d;
  assign clearing = (state_q == gtd_pkg::GTD_CLEAR);
  assign converting = (state_q == gtd_pkg::GTD_FULLSCALE);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      interp_d[i] = interp_q[i];
      coarse_d[i] = coarse_q[i];
      hold_d[i] = hold_q[i];
      if (clearing) begin
        interp_d[i] = gtd_pkg::PHASE_RESET;
        coarse_d[i] = '0;
      end else if (converting && time_s_q[i]) begin
        // Transparent while the pulse is high; last value kept once it falls
        interp_d[i] = phase_d;
        if (interp_q[i][PB-1] && !phase_d[PB-1]) begin
          coarse_d[i] = coarse_q[i] + 1'b1;
        end
      end
      if (converting) begin
        hold_d[i] = coarse_d[i];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interp_q <= '0;
      coarse_q <= '0;
      hold_q <= '0;
    end else begin
      interp_q <= interp_d;
      coarse_q <= coarse_d;
      hold_q <= hold_d;
    end
  end

  // ----------------------------------------
  // Readout bus and status outputs
  // ----------------------------------------
  logic [gtd_pkg::RESULT_BITS-1:0] data_q, data_d;
  logic oe_q, oe_d, integ_q, fs_q, clr_q;
  always_comb begin
    // Only the selected channel drives, and only outside conversion
    oe_d = readout_en && (state_q == gtd_pkg::GTD_IDLE);
    data_d = {hold_q[readout_sel], gtd_phase_to_bin(interp_q[readout_sel])};
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      data_q <= '0;
      oe_q <= 1'b0;
      integ_q <= 1'b0;
      fs_q <= 1'b0;
      clr_q <= 1'b0;
    end else begin
      data_q <= data_d;
      oe_q <= oe_d;
      integ_q <= window_d;
      fs_q <= (state_d == gtd_pkg::GTD_FULLSCALE);
      clr_q <= (state_d == gtd_pkg::GTD_CLEAR);
    end
  end
  assign integ_window = integ_q;
  assign charge_switch = charge_q;
  assign full_scale_window = fs_q;
  assign counter_clear = clr_q;
  assign readout_data = data_q;
  assign readout_oe = oe_q;
endmodule : gtd_digitizer
`default_nettype wire

// file: gtd_digitizer_assertions.sv
// Checker for the gated time digitizer sequencer outputs.
// Bound to gtd_digitizer; sees its ports only.
`default_nettype none
module gtd_digitizer_assertions #(
  parameter int unsigned FULL_SCALE_CYC = 2100
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic readout_en,
  input wire logic integ_window,
  input wire logic charge_switch,
  input wire logic full_scale_window,
  input wire logic counter_clear,
  input wire logic readout_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [15:0] fs_cnt_q;
  always_ff @(posedge clk) begin
    fs_cnt_q <= (rst_n && full_scale_window) ? fs_cnt_q + 16'h1 : 16'h0;
  end
  property p_cs_delay; $rose(charge_switch) |-> $past(integ_window) && !$past(integ_window, 2); endproperty
  a_cs_delay: assert property (p_cs_delay) else $error("charge switch delay wrong");
  property p_cs_len; $rose(charge_switch) |-> ##19 charge_switch ##1 !charge_switch; endproperty
  a_cs_len: assert property (p_cs_len) else $error("charge switch width wrong");
  property p_win_cs; charge_switch |-> integ_window; endproperty
  a_win_cs: assert property (p_win_cs) else $error("charge switch outside window");
  property p_clr_start; $fell(integ_window) |-> ##[0:3] counter_clear; endproperty
  a_clr_start: assert property (p_clr_start) else $error("no clear after window");
  property p_clr_len; $rose(counter_clear) |-> ##15 counter_clear ##1 !counter_clear; endproperty
  a_clr_len: assert property (p_clr_len) else $error("clear width wrong");
  property p_fs_start; $fell(counter_clear) |-> ##[0:1] full_scale_window; endproperty
  a_fs_start: assert property (p_fs_start) else $error("full scale not after clear");
  property p_fs_len; $fell(full_scale_window) |-> fs_cnt_q == FULL_SCALE_CYC; endproperty
  a_fs_len: assert property (p_fs_len) else $error("full scale length wrong");
  property p_oe; readout_oe |-> $past(readout_en) && !full_scale_window; endproperty
  a_oe: assert property (p_oe) else $error("readout driven while busy");
  c_test: cover property ($rose(charge_switch));
  c_conv: cover property ($fell(full_scale_window));
  c_read: cover property (readout_oe);
endmodule : gtd_digitizer_assertions
`default_nettype wire

// file: gtd_pkg.sv
// Constants shared by the gated time digitizer.
// Assumes a single 40 MHz system clock.
`default_nettype none
package gtd_pkg;
  localparam int unsigned CLK_PERIOD_PS = 25000;
  localparam int unsigned NUM_CHANNELS = 16;
  localparam int unsigned COARSE_BITS = 8;
  localparam int unsigned FINE_BITS = 3;
  localparam int unsigned PHASE_BITS = 4;
  localparam int unsigned RESULT_BITS = COARSE_BITS + FINE_BITS;
  // Least times round up to whole cycles
  localparam int unsigned TEST_PULSE_NS = 550;
  localparam int unsigned TEST_PULSE_CYC = (TEST_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CHARGE_DELAY_NS = 20;
  localparam int unsigned CHARGE_DELAY_CYC = (CHARGE_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned CLEAR_NS = 400;
  localparam int unsigned CLEAR_CYC = (CLEAR_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Full scale: 256 coarse wraps of 8 fine steps, plus margin
  localparam int unsigned FULL_SCALE_CYC = 2100;
  localparam int unsigned CNT_BITS = 12;
  localparam logic [3:0] PHASE_RESET = 4'h0;
  typedef enum logic [1:0] {GTD_IDLE, GTD_INTEG, GTD_CLEAR, GTD_FULLSCALE} gtd_state_t;
endpackage : gtd_pkg
`default_nettype wire

// file: gtd_qtc_model.sv
// Charge-to-time converter outputs: pulse on with the window, off a
// channel-dependent count of cycles into the full-scale window.
`default_nettype none
module gtd_qtc_model (
  input wire logic clk,
  input wire logic integ_window,
  input wire logic full_scale_window,
  output logic [15:0] time_pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  initial time_pulse = '0;
  always @(posedge clk) begin
    cnt <= full_scale_window ? cnt + 1 : 0;
    for (int i = 0; i < 16; i++) begin
      if (integ_window) time_pulse[i] <= 1'b1;
      else if (full_scale_window && cnt >= i * 137 + 3) time_pulse[i] <= 1'b0;
    end
  end
endmodule : gtd_qtc_model
`default_nettype wire
